// ==== src/half_bridge_fault_latch.sv ====
// Fault latching and output gating for a twelve-bridge driver
`timescale 1ns/1ns
// Summary of operation
// - Overcurrent persisting for the filter time latches switch off and sets its flag.
// - Any latched overcurrent or open-load flag also sets load-error summary bit 6.
// - A switch latched off stays off while its overcurrent flag stays set.
// - Activation bits stay 1; flags read 0 until latch-off, then 1.
// - Separate high-side and low-side overcurrent flags in three status registers.
// - Thermal pre-warning latches bit 1, pulls fault pin low, outputs unchanged.
// - Thermal shutdown latches bit 2; all outputs off until flag cleared.
// - Undervoltage latches bit 5; outputs off, auto-recover, flag stays latched.
// - Overvoltage latches bit 4; outputs off, auto-recover, flag stays latched.
// - High side guards shorts to ground, low side shorts to supply.
// - Every fault flag is sticky and cleared only by the host.
// - Open load latches its flag and summary but keeps output activated.
// - Fault pin goes low whenever a global fault is present or any fault flag is latched.
module half_bridge_fault_latch
   import hb_fault_pkg::*;
#(
   parameter logic [TIMER_W-1:0] FILTER_CYCLES_P = TIMER_W'(FILTER_CYCLES)
)
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Analog comparator outputs, asynchronous
   input wire hb_fault_pkg::fault_pins_t fault_pins,
   // AXI4-Lite slave
   input wire hb_fault_pkg::axi_req_t axi_in,
   output hb_fault_pkg::axi_rsp_t axi_out,
   // Power stage gates and fault signalling
   output hb_fault_pkg::bridge_t drive,
   output logic fault_out_n,
   output logic irq
);
   import hb_fault_pkg::*;

   // All state lives in one struct; s_next is its next value
   state_t s, s_next;

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[8*b +: 8] = wd[8*b +: 8];
      end
      return r;
   endfunction

   // Four bridges per word: high sides low nibble, low sides high nibble
   function automatic logic [31:0] chan_word(input bridge_t f,
                                             input int k);
      logic [31:0] r;
      r = '0;
      r[0 +: BRIDGES_PER_REG] = f.hs[k*BRIDGES_PER_REG +: BRIDGES_PER_REG];
      r[LS_FIELD_LSB +: BRIDGES_PER_REG] =
         f.ls[k*BRIDGES_PER_REG +: BRIDGES_PER_REG];
      return r;
   endfunction

   // Index 0..2 of a channel status word at a base, or -1
   function automatic int chan_index(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
      int r;
      r = -1;
      for (int k = 0; k < NUM_BRIDGES / BRIDGES_PER_REG; k++)
      begin
         if (a == base + ADDR_W'(k) * REG_STEP)
            r = k;
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == ACT_OFS || a == GSTAT_OFS || a == MASK_OFS ||
             chan_index(a, OC_A_OFS) >= 0 || chan_index(a, OL_A_OFS) >= 0;
   endfunction

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb
   begin
      fault_pins_t p;
      logic [31:0] act_word;
      logic [31:0] rd;
      logic [GSTAT_W-1:0] g_set;
      logic [GSTAT_W-1:0] g_clr;
      bridge_t oc_set;
      bridge_t oc_clr;
      bridge_t ol_set;
      bridge_t ol_clr;
      logic rd_take;
      logic wr_commit;
      logic supply_bad;
      int k_oc;
      int k_ol;
      logic [2*NUM_BRIDGES-1:0] oc_live;
      logic [2*NUM_BRIDGES-1:0] on_now;
      logic [2*NUM_BRIDGES-1:0] oc_hit;
      p = s.sync2;
      act_word = '0;
      rd = '0;
      g_set = '0;
      g_clr = '0;
      oc_set = '0;
      oc_clr = '0;
      ol_set = '0;
      ol_clr = '0;
      oc_live = '0;
      on_now = '0;
      oc_hit = '0;
      rd_take = 1'b0;
      wr_commit = 1'b0;
      supply_bad = 1'b0;
      k_oc = -1;
      k_ol = -1;
      s_next = s;

      // ****************************************************************
      // Synchroniser and overcurrent filters
      // ****************************************************************
      // Two-stage synchroniser; only stage two is looked at
      s_next.sync1 = fault_pins;
      s_next.sync2 = s.sync1;

      // Comparator polarity per side is fixed in the analog stage (high
      // side to ground, low side to supply). Index 0..11 is the high side.
      oc_live = {p.overcurrent.ls, p.overcurrent.hs};
      on_now = {s.drive.ls, s.drive.hs};
      // A switch that is off cannot carry the fault, so its timer rests;
      // after a clear with the short still present the filter runs again
      for (int i = 0; i < 2*NUM_BRIDGES; i++)
      begin
         if (oc_live[i] && on_now[i])
         begin
            if (s.timer[i] >= FILTER_CYCLES_P - TIMER_W'(1))
            begin
               s_next.timer[i] = '0;
               oc_hit[i] = 1'b1;
            end
            else
               s_next.timer[i] = s.timer[i] + TIMER_W'(1);
         end
         else
            s_next.timer[i] = '0;
      end
      oc_set.hs = oc_hit[NUM_BRIDGES-1:0];
      oc_set.ls = oc_hit[2*NUM_BRIDGES-1:NUM_BRIDGES];

      // Open load only judged on a switch that is driven on; the input arrives
      // already filtered, so one synced cycle is enough to latch it
      ol_set.hs = p.open_load.hs & s.drive.hs;
      ol_set.ls = p.open_load.ls & s.drive.ls;

      // ****************************************************************
      // Register reads
      // ****************************************************************
      // AXI read: data sampled and flags cleared at the address handshake
      rd_take = axi_in.arvalid && s.rsp.arready;
      if (rd_take)
      begin
         k_oc = chan_index(axi_in.araddr, OC_A_OFS);
         k_ol = chan_index(axi_in.araddr, OL_A_OFS);
         if (axi_in.araddr == ACT_OFS)
         begin
            rd[HS_ACT_LSB +: NUM_BRIDGES] = s.activate.hs;
            rd[LS_ACT_LSB +: NUM_BRIDGES] = s.activate.ls;
         end
         else if (axi_in.araddr == GSTAT_OFS)
         begin
            rd[GSTAT_W-1:0] = s.gstat;
            g_clr = '1;
         end
         else if (axi_in.araddr == MASK_OFS)
            rd[GSTAT_W-1:0] = s.mask;
         else if (k_oc >= 0)
         begin
            rd = chan_word(s.oc_flag, k_oc);
            oc_clr.hs[k_oc*BRIDGES_PER_REG +: BRIDGES_PER_REG] = '1;
            oc_clr.ls[k_oc*BRIDGES_PER_REG +: BRIDGES_PER_REG] = '1;
         end
         else if (k_ol >= 0)
         begin
            rd = chan_word(s.ol_flag, k_ol);
            ol_clr.hs[k_ol*BRIDGES_PER_REG +: BRIDGES_PER_REG] = '1;
            ol_clr.ls[k_ol*BRIDGES_PER_REG +: BRIDGES_PER_REG] = '1;
         end
         s_next.rsp.rvalid = 1'b1;
         s_next.rsp.rdata = rd;
         s_next.rsp.rresp = mapped(axi_in.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s.rsp.rvalid && axi_in.rready)
         s_next.rsp.rvalid = 1'b0;

      // ****************************************************************
      // Status latches
      // ****************************************************************
      // Sticky flags: a set in the clearing cycle wins
      s_next.oc_flag = (s.oc_flag & ~oc_clr) | oc_set;
      s_next.ol_flag = (s.ol_flag & ~ol_clr) | ol_set;

      g_set[PREWARN_BIT] = p.temp_warn;
      g_set[TSD_BIT] = p.temp_shut;
      g_set[UV_BIT] = p.supply_under;
      g_set[OV_BIT] = p.supply_over;
      // Summary re-asserts while any channel flag is still latched
      g_set[LE_BIT] = |{s_next.oc_flag, s_next.ol_flag};
      s_next.gstat = (s.gstat & ~g_clr) | g_set;

      // ****************************************************************
      // Register writes
      // ****************************************************************
      // AXI write: address and data taken in either order
      if (axi_in.awvalid && s.rsp.awready)
      begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = axi_in.awaddr;
      end
      if (axi_in.wvalid && s.rsp.wready)
      begin
         s_next.w_have = 1'b1;
         s_next.w_data = axi_in.wdata;
         s_next.w_strb = axi_in.wstrb;
      end
      wr_commit = s.aw_have && s.w_have && !s.rsp.bvalid;
      if (wr_commit)
      begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.rsp.bvalid = 1'b1;
         s_next.rsp.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         // Status words take no writes: a read is their only clear
         // Faults never touch the activation bits, only software does
         if (s.aw_addr == ACT_OFS)
         begin
            act_word[HS_ACT_LSB +: NUM_BRIDGES] = s.activate.hs;
            act_word[LS_ACT_LSB +: NUM_BRIDGES] = s.activate.ls;
            act_word = merge(act_word, s.w_data, s.w_strb);
            s_next.activate.hs = act_word[HS_ACT_LSB +: NUM_BRIDGES];
            s_next.activate.ls = act_word[LS_ACT_LSB +: NUM_BRIDGES];
         end
         else if (s.aw_addr == MASK_OFS)
            s_next.mask = GSTAT_W'(merge(32'(s.mask), s.w_data, s.w_strb));
      end
      else if (s.rsp.bvalid && axi_in.bready)
         s_next.rsp.bvalid = 1'b0;

      s_next.rsp.awready = !s_next.aw_have && !s_next.rsp.bvalid;
      s_next.rsp.wready = !s_next.w_have && !s_next.rsp.bvalid;
      s_next.rsp.arready = !s_next.rsp.rvalid;

      // ****************************************************************
      // Output gating and fault signalling
      // ****************************************************************
      // Output gating. Supply faults act on the live level so stages
      // come back by themselves; thermal shutdown holds on the flag.
      supply_bad = p.supply_under || p.supply_over;
      if (s_next.gstat[TSD_BIT] || supply_bad)
         s_next.drive = '0;
      else
      begin
         s_next.drive.hs = s.activate.hs & ~s_next.oc_flag.hs;
         s_next.drive.ls = s.activate.ls & ~s_next.oc_flag.ls;
      end

      // Pin stays low while a fault is live or still latched
      s_next.fault_n = !(|s_next.gstat || |g_set);
      s_next.irq = |(s_next.gstat & s_next.mask);
   end

   // ********************************************************************
   // State register
   // ********************************************************************
   always_ff @(posedge aclk)
   begin
      // Reset acts whatever the enable does
      if (!aresetn)
      begin
         s <= '0;
         s.fault_n <= 1'b1;
      end
      else if (ce)
         s <= s_next;
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign axi_out = s.rsp;
   assign drive = s.drive;
   assign fault_out_n = s.fault_n;
   assign irq = s.irq;

endmodule // half_bridge_fault_latch

// ==== src/hb_fault_pkg.sv ====
// Constants, register map and carrier types of the half-bridge fault latch
package hb_fault_pkg;

   // ********************************************************************
   // Geometry and timing
   // ********************************************************************
   localparam int NUM_BRIDGES = 12;
   localparam int CLK_PERIOD_NS = 10;
   // Filter time has no fixed figure; plain default, override as needed
   localparam int SHUTDOWN_FILTER_NS = 5000;
   localparam int FILTER_CYCLES =
      (SHUTDOWN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;

   // ********************************************************************
   // Register map (byte addresses)
   // ********************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ACT_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] GSTAT_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] OC_A_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] OC_B_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] OC_C_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] OL_A_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] OL_B_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] OL_C_OFS = 8'h1c;
   localparam logic [ADDR_W-1:0] MASK_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] REG_STEP = 8'h04;

   // Fields
   localparam int HS_ACT_LSB = 0;
   localparam int LS_ACT_LSB = 16;
   localparam int PREWARN_BIT = 1;
   localparam int TSD_BIT = 2;
   localparam int OV_BIT = 4;
   localparam int UV_BIT = 5;
   localparam int LE_BIT = 6;
   localparam int GSTAT_W = 8;
   localparam int BRIDGES_PER_REG = 4;
   localparam int LS_FIELD_LSB = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************************************************
   // Carrier types
   // ********************************************************************
   typedef struct packed {
      logic [NUM_BRIDGES-1:0] hs;
      logic [NUM_BRIDGES-1:0] ls;
   } bridge_t;

   typedef struct packed {
      bridge_t overcurrent;
      bridge_t open_load;
      logic temp_warn;
      logic temp_shut;
      logic supply_under;
      logic supply_over;
   } fault_pins_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

   typedef struct packed {
      fault_pins_t sync1;
      fault_pins_t sync2;
      bridge_t activate;
      bridge_t oc_flag;
      bridge_t ol_flag;
      logic [2*NUM_BRIDGES-1:0][TIMER_W-1:0] timer;
      logic [GSTAT_W-1:0] gstat;
      logic [GSTAT_W-1:0] mask;
      bridge_t drive;
      logic fault_n;
      logic irq;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      axi_rsp_t rsp;
   } state_t;

endpackage

// ==== dv/hb_fault_properties.sv ====
// Port-level assertions for the half-bridge fault latch
`timescale 1ns/1ns
module hb_fault_properties
   import hb_fault_pkg::*;
#(
   parameter logic [TIMER_W-1:0] FILTER_CYCLES_P = TIMER_W'(FILTER_CYCLES)
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Inputs of the block
   input wire hb_fault_pkg::fault_pins_t fault_pins,
   input wire hb_fault_pkg::axi_req_t axi_in,
   // Outputs of the block
   input wire hb_fault_pkg::axi_rsp_t axi_out,
   input wire hb_fault_pkg::bridge_t drive,
   input wire logic fault_out_n,
   input wire logic irq
);
   // ********************************************************************
   // Properties
   // ********************************************************************
   default clocking cb @(posedge aclk); endclocking
   // Enable low freezes the block, so nothing is judged meanwhile
   default disable iff (!aresetn || !ce);
   logic quiet;
   logic glob;
   // Live channel pins may pull the pin low on their own, so stay clear
   assign quiet = fault_pins.overcurrent == '0 && fault_pins.open_load == '0;
   assign glob = fault_pins.temp_warn | fault_pins.temp_shut |
      fault_pins.supply_under | fault_pins.supply_over;

   a_oc_hs_off: assert property (
      (fault_pins.overcurrent.hs[3] && drive.hs[3]) ##1
      fault_pins.overcurrent.hs[3] [*8] |-> ##[0:3] !drive.hs[3])
      else $error("high side stayed on in overcurrent");
   a_oc_ls_off: assert property (
      (fault_pins.overcurrent.ls[9] && drive.ls[9]) ##1
      fault_pins.overcurrent.ls[9] [*8] |-> ##[0:3] !drive.ls[9])
      else $error("low side stayed on in overcurrent");
   a_prewarn_pin: assert property (
      fault_pins.temp_warn [*3] |-> ##[1:2] !fault_out_n)
      else $error("prewarning did not pull fault pin low");
   a_shut_all_off: assert property (
      fault_pins.temp_shut [*3] |-> ##[1:2] drive == '0)
      else $error("outputs on during thermal shutdown");
   a_under_all_off: assert property (
      fault_pins.supply_under [*3] |-> ##[1:2] drive == '0)
      else $error("outputs on during undervoltage");
   a_over_all_off: assert property (
      fault_pins.supply_over [*3] |-> ##[1:2] drive == '0)
      else $error("outputs on during overvoltage");
   a_any_fault_pin: assert property (
      glob [*3] |-> ##[1:2] !fault_out_n)
      else $error("fault pin high during a fault");
   a_flag_sticky: assert property (
      quiet [*4] ##0 (!fault_out_n && !axi_out.rvalid &&
      !(axi_in.arvalid && axi_out.arready)) |=> !fault_out_n)
      else $error("fault pin released without a read");

   c_oc_trip: cover property (fault_pins.overcurrent.hs[3] ##1 !drive.hs[3]);
   c_irq: cover property (irq);
   c_slverr: cover property (axi_out.rvalid && axi_out.rresp == RESP_SLVERR);
endmodule // hb_fault_properties

// ==== dv/host_model.sv ====
// Host that reads and clears the fault flags over AXI4-Lite
`timescale 1ns/1ns
module host_model
   import hb_fault_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Bus towards the block
   output hb_fault_pkg::axi_req_t req,
   input wire hb_fault_pkg::axi_rsp_t rsp
);
   // ********************************************************************
   // Bus cycles
   // ********************************************************************
   initial req = '0;

   // Address and data go up together; each drops once its ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] dat,
      output logic [1:0] resp);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= dat;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      while (!rsp.bvalid);
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   // A status read is the host's clear of the flags it returns
   task automatic rd(input logic [7:0] a, output logic [31:0] dat,
      output logic [1:0] resp);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      while (!rsp.rvalid);
      dat = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask
endmodule // host_model

// ==== dv/half_bridge_fault_latch_tb_top.sv ====
// Self-checking bench for the half-bridge fault latch
`timescale 1ns/1ns
module half_bridge_fault_latch_tb_top;
   import hb_fault_pkg::*;
   logic aclk;
   logic aresetn;
   logic ce;
   fault_pins_t fault_pins;
   axi_req_t axi_in;
   axi_rsp_t axi_out;
   bridge_t drive;
   logic fault_out_n;
   logic irq;
   int err_count;
   int n_tests;
   logic [31:0] d;
   logic [1:0] r;
   localparam logic [31:0] ALL_ON = 32'h00ffffff;

   // Short filter keeps the overcurrent cases brief
   half_bridge_fault_latch #(.FILTER_CYCLES_P(16'h0004)) dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .fault_pins(fault_pins),
      .axi_in(axi_in),
      .axi_out(axi_out),
      .drive(drive),
      .fault_out_n(fault_out_n),
      .irq(irq)
   );
   host_model host (.aclk(aclk), .req(axi_in), .rsp(axi_out));

   // ********************************************************************
   // Helpers and scenarios
   // ********************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic t_bus;
      cyc(1);
      chk(32'(fault_out_n), 32'h1);
      host.rd(8'h24, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
      host.wr(8'h24, 32'hffffffff, r);
      chk(32'(r), 32'(RESP_SLVERR));
      host.wr(GSTAT_OFS, 32'h000000ff, r);
      chk(32'(r), 32'(RESP_OKAY));
      host.rd(GSTAT_OFS, d, r);
      chk(d, 32'h0);
      host.wr(ACT_OFS, 32'h0fff0fff, r);
      chk(32'(r), 32'(RESP_OKAY));
      host.wr(MASK_OFS, 32'h02, r);
      host.rd(MASK_OFS, d, r);
      chk(d, 32'h02);
      chk(32'(r), 32'(RESP_OKAY));
      cyc(2);
      chk({8'h0, drive}, ALL_ON);
   endtask

   task automatic t_oc;
      @(posedge aclk);
      fault_pins.overcurrent.hs[3] <= 1'b1;
      fault_pins.overcurrent.ls[9] <= 1'b1;
      host.rd(OC_A_OFS, d, r);
      chk(d, 32'h0);
      cyc(12);
      chk({8'h0, drive}, 32'h00ff7dff);
      @(posedge aclk);
      fault_pins.overcurrent <= '0;
      cyc(8);
      chk({8'h0, drive}, 32'h00ff7dff);
      host.rd(ACT_OFS, d, r);
      chk(d, 32'h0fff0fff);
      host.rd(OC_A_OFS, d, r);
      chk(d, 32'h08);
      chk(32'(r), 32'(RESP_OKAY));
      host.rd(OC_C_OFS, d, r);
      chk(d, 32'h20);
      host.rd(GSTAT_OFS, d, r);
      chk(d, 32'h40);
      cyc(2);
      chk({8'h0, drive}, ALL_ON);
   endtask

   task automatic t_short;
      @(posedge aclk);
      fault_pins.overcurrent.hs[3] <= 1'b1;
      repeat (2) @(posedge aclk);
      fault_pins.overcurrent.hs[3] <= 1'b0;
      cyc(10);
      chk({8'h0, drive}, ALL_ON);
      host.rd(OC_A_OFS, d, r);
      chk(d, 32'h0);
   endtask

   task automatic t_ol;
      @(posedge aclk);
      fault_pins.open_load.ls[0] <= 1'b1;
      cyc(6);
      chk({8'h0, drive}, ALL_ON);
      chk(32'(fault_out_n), 32'h0);
      @(posedge aclk);
      fault_pins.open_load <= '0;
      cyc(4);
      host.rd(OL_A_OFS, d, r);
      chk(d, 32'h10);
      host.rd(GSTAT_OFS, d, r);
      chk(d, 32'h40);
   endtask

   // Low nibble of the pin struct: warn, shutdown, under, over
   task automatic t_glob;
      int b [4] = '{PREWARN_BIT, TSD_BIT, UV_BIT, OV_BIT};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge aclk);
         fault_pins[3:0] <= 4'h8 >> i;
         cyc(6);
         chk(32'(fault_out_n), 32'h0);
         chk(32'(irq), 32'(i == 0));
         chk({8'h0, drive}, i == 0 ? ALL_ON : 32'h0);
         @(posedge aclk);
         fault_pins[3:0] <= 4'h0;
         cyc(6);
         chk({8'h0, drive}, i == 1 ? 32'h0 : ALL_ON);
         host.rd(GSTAT_OFS, d, r);
         chk(d, 32'h1 << b[i]);
         cyc(2);
         chk({8'h0, drive}, ALL_ON);
         chk(32'(fault_out_n), 32'h1);
      end
   endtask

   // Enable low must freeze synchronisers and gating alike
   task automatic t_hold;
      @(posedge aclk);
      ce <= 1'b0;
      fault_pins.supply_under <= 1'b1;
      cyc(6);
      chk({8'h0, drive}, ALL_ON);
      chk(32'(fault_out_n), 32'h1);
      @(posedge aclk);
      fault_pins.supply_under <= 1'b0;
      cyc(3);
      @(posedge aclk);
      ce <= 1'b1;
      cyc(6);
      chk({8'h0, drive}, ALL_ON);
      chk(32'(fault_out_n), 32'h1);
      host.rd(GSTAT_OFS, d, r);
      chk(d, 32'h0);
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      wrap_up();
   end

   initial
   begin
      err_count = 0;
      n_tests = 0;
      aresetn = 1'b0;
      ce = 1'b1;
      fault_pins = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_bus();
      t_oc();
      t_short();
      t_ol();
      t_glob();
      t_hold();
      wrap_up();
   end
endmodule // half_bridge_fault_latch_tb_top

bind half_bridge_fault_latch hb_fault_properties
   #(.FILTER_CYCLES_P(FILTER_CYCLES_P)) props (
   .aclk(aclk),
   .aresetn(aresetn),
   .ce(ce),
   .fault_pins(fault_pins),
   .axi_in(axi_in),
   .axi_out(axi_out),
   .drive(drive),
   .fault_out_n(fault_out_n),
   .irq(irq)
);
